/* ebra_top.sv */
// External bus cycle engine with ready control and hold arbitration
`timescale 1ns/1ps
module ebra_top #(
    parameter int AW = 16,  // External address width
    parameter int DW = 16   // External data width
) (
    input wire logic pclk,                   // System clock, 50 MHz
    input wire logic presetn,                // Asynchronous reset, active low
    input wire logic psel,                   // APB select
    input wire logic penable,                // APB enable
    input wire logic pwrite,                 // APB write
    input wire logic [7:0] paddr,            // APB byte address
    input wire logic [31:0] pwdata,          // APB write data
    output logic [31:0] prdata,              // APB read data
    output logic pready,                     // APB ready
    output logic pslverr,                    // APB error on unmapped address
    output logic system_clock_output,        // Output clock, pclk / 2
    output logic [AW-1:0] ext_addr_o,        // External address
    output logic ext_addr_oe,                // Address drive enable
    input wire logic [DW-1:0] ext_data_i,    // External data in
    output logic [DW-1:0] ext_data_o,        // External data out
    output logic ext_data_oe,                // Data drive enable
    output logic ext_rd_n_o,                 // Read strobe, active low
    output logic ext_wr_n_o,                 // Write strobe, active low
    output logic ext_strobe_oe,              // Strobe drive enable
    output logic ext_cs_n_o,                 // Chip select, active low
    output logic ext_cs_n_oe,                // Chip select drive enable
    input wire logic ext_ready_n,            // Ready, active low
    input wire logic ext_hold_n,             // Hold request, active low
    output logic bus_hold_grant_out,         // Hold acknowledge, active high
    output logic bus_regain_request_out      // Bus request, active high
);
    import ebra_pkg::*;

    typedef struct packed {
        logic clk_out;
        ebra_cyc_st_t st;
        logic [3:0] wcnt;
        logic [6:0] ctrl;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic [DW-1:0] rdata;
        logic pend;
        logic is_wr;
        logic done;
        logic [31:0] prdata;
    } ebra_state_t;

    ebra_state_t s_q;
    ebra_state_t s_d;
    ebra_arb_if arb_if ();

    logic tick;
    logic setup;
    logic wr_acc;
    logic mapped;
    logic strobe;
    logic in_cycle;
    logic [3:0] memory_cycle_wait_count;

    ebra_arbiter u_arb (
        .pclk(pclk),
        .presetn(presetn),
        .arb(arb_if.arb)
    );

    // Output clock rises when tick is high
    assign tick = !s_q.clk_out;
    assign memory_cycle_wait_count = s_q.ctrl[EBRA_CTRL_WAIT_LSB +: 4];
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign mapped = paddr[1:0] == 2'b00 && paddr <= EBRA_OFF_RDATA;

    assign arb_if.tick = tick;
    assign arb_if.hold_n = ext_hold_n;
    assign arb_if.cyc_idle = s_q.st == CYC_IDLE;
    assign arb_if.pending = s_q.pend;

    function automatic ebra_cyc_st_t after_end(input logic [6:0] c);
        if (c[EBRA_CTRL_MUX])
            after_end = CYC_MUX;
        else if (c[EBRA_CTRL_TRI])
            after_end = CYC_TRI;
        else
            after_end = CYC_IDLE;
    endfunction : after_end

    always_comb
    begin
        s_d = s_q;
        s_d.clk_out = !s_q.clk_out;
        if (setup)
        begin
            unique case (paddr)
                EBRA_OFF_CTRL: s_d.prdata = {25'h0, s_q.ctrl};
                EBRA_OFF_ADDR: s_d.prdata = 32'(s_q.addr);
                EBRA_OFF_WDATA: s_d.prdata = 32'(s_q.wdata);
                EBRA_OFF_STATUS: s_d.prdata = {26'h0,
                    arb_if.regain_req, arb_if.grant, s_q.done,
                    s_q.st != CYC_IDLE, s_q.is_wr, s_q.pend};
                EBRA_OFF_RDATA: s_d.prdata = 32'(s_q.rdata);
                default: s_d.prdata = 32'h00000000;
            endcase
        end
        if (wr_acc)
        begin
            if (paddr == EBRA_OFF_CTRL)
                s_d.ctrl = pwdata[6:0];
            if (paddr == EBRA_OFF_ADDR && !s_q.pend)
                s_d.addr = pwdata[AW-1:0];
            if (paddr == EBRA_OFF_WDATA && !s_q.pend)
                s_d.wdata = pwdata[DW-1:0];
            if (paddr == EBRA_OFF_CMD && !s_q.pend && pwdata[EBRA_CMD_START])
            begin
                s_d.pend = 1'b1;
                s_d.is_wr = pwdata[EBRA_CMD_WRITE];
                s_d.done = 1'b0;
            end
        end
        if (tick)
        begin
            unique case (s_q.st)
                CYC_IDLE:
                    if (s_q.pend && arb_if.may_start)
                        s_d.st = CYC_ADDR;
                CYC_ADDR:
                    // Read/write delay holds the strobe back a clock
                    s_d.st = s_q.ctrl[EBRA_CTRL_RWDLY] ? CYC_DLY : CYC_CMD;
                CYC_DLY:
                    s_d.st = CYC_CMD;
                CYC_CMD:
                begin
                    s_d.wcnt = 4'h1;
                    // Programmed wait states come before ready is sampled
                    s_d.st = (memory_cycle_wait_count == 4'h0) ? CYC_RDY : CYC_WAIT;
                end
                CYC_WAIT:
                begin
                    s_d.wcnt = s_q.wcnt + 4'h1;
                    if (s_q.wcnt == memory_cycle_wait_count)
                        s_d.st = CYC_RDY;
                end
                CYC_RDY:
                    // High ready_n stays here one more clock
                    if (!ext_ready_n)
                    begin
                        // Data taken on the strobe-ending edge
                        if (!s_q.is_wr)
                            s_d.rdata = ext_data_i;
                        s_d.pend = 1'b0;
                        s_d.done = 1'b1;
                        s_d.st = after_end(s_q.ctrl);
                    end
                CYC_MUX:
                    s_d.st = s_q.ctrl[EBRA_CTRL_TRI] ? CYC_TRI : CYC_IDLE;
                CYC_TRI:
                    s_d.st = CYC_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '{clk_out: 1'b0, st: CYC_IDLE, ctrl: EBRA_CTRL_RESET,
                     default: '0};
        else
            s_q <= s_d;
    end

    assign in_cycle = s_q.st inside {CYC_ADDR, CYC_DLY, CYC_CMD, CYC_WAIT,
                                     CYC_RDY};
    assign strobe = s_q.st inside {CYC_CMD, CYC_WAIT, CYC_RDY};

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = s_q.prdata;
    assign system_clock_output = s_q.clk_out;
    assign ext_addr_o = s_q.addr;
    assign ext_addr_oe = arb_if.drive_en;
    assign ext_data_o = s_q.wdata;
    assign ext_data_oe = arb_if.drive_en && in_cycle && s_q.is_wr;
    assign ext_rd_n_o = !(strobe && !s_q.is_wr);
    assign ext_wr_n_o = !(strobe && s_q.is_wr);
    assign ext_strobe_oe = arb_if.drive_en;
    assign ext_cs_n_o = !in_cycle;
    // Released chip selects float to the pull-ups
    assign ext_cs_n_oe = arb_if.drive_en;
    assign bus_hold_grant_out = arb_if.grant;
    assign bus_regain_request_out = arb_if.regain_req;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_wait: assert property (s_q.st == CYC_RDY && tick && ext_ready_n
        |=> s_q.st == CYC_RDY && strobe)
        else $error("High ready did not extend the cycle");
    a_ready_end: assert property (s_q.st == CYC_RDY && tick && !ext_ready_n
        |=> !strobe && ext_cs_n_o)
        else $error("Low ready did not end the cycle");
    a_read_capture: assert property (s_q.st == CYC_RDY && tick &&
        !ext_ready_n && !s_q.is_wr |=> s_q.rdata == $past(ext_data_i))
        else $error("Read data not taken at strobe end");
    a_rw_delay: assert property ($rose(in_cycle) && s_q.ctrl[EBRA_CTRL_RWDLY]
        |-> !strobe [*4] ##1 strobe)
        else $error("Delayed strobe started at the wrong clock");
    a_no_delay: assert property ($rose(in_cycle) &&
        !s_q.ctrl[EBRA_CTRL_RWDLY] |-> !strobe [*2] ##1 strobe)
        else $error("Undelayed strobe started at the wrong clock");
    a_wait_length: assert property ($rose(strobe) && memory_cycle_wait_count == 4'h3 &&
        $stable(s_q.ctrl) |-> s_q.st != CYC_RDY [*8])
        else $error("Ready sampled before programmed wait states");
    a_mux_gap: assert property ($fell(in_cycle) && s_q.ctrl[EBRA_CTRL_MUX]
        && s_q.ctrl[EBRA_CTRL_TRI] |-> s_q.st == CYC_MUX ##2
        s_q.st == CYC_TRI ##2 s_q.st == CYC_IDLE)
        else $error("Mux and tristate gap not two output clocks");
    a_demux_gap: assert property ($fell(in_cycle) &&
        s_q.ctrl[6:5] == 2'b00 |-> s_q.st == CYC_IDLE)
        else $error("Demux cycle without tristate left a gap");
    a_cs_float: assert property (bus_hold_grant_out |->
        !ext_cs_n_oe && !ext_addr_oe && !ext_data_oe)
        else $error("Outputs driven while bus granted");
endmodule : ebra_top

/* ebra_pkg.sv */
// Package: constants and types for the external bus ready and hold block
package ebra_pkg;
    localparam logic [7:0] EBRA_OFF_CTRL = 8'h00;
    localparam logic [7:0] EBRA_OFF_ADDR = 8'h04;
    localparam logic [7:0] EBRA_OFF_WDATA = 8'h08;
    localparam logic [7:0] EBRA_OFF_CMD = 8'h0C;
    localparam logic [7:0] EBRA_OFF_STATUS = 8'h10;
    localparam logic [7:0] EBRA_OFF_RDATA = 8'h14;
    localparam int EBRA_CTRL_WAIT_LSB = 0;
    localparam int EBRA_CTRL_RWDLY = 4;
    localparam int EBRA_CTRL_TRI = 5;
    localparam int EBRA_CTRL_MUX = 6;
    localparam int EBRA_CMD_START = 0;
    localparam int EBRA_CMD_WRITE = 1;
    localparam logic [6:0] EBRA_CTRL_RESET = 7'h00;
    localparam int EBRA_CLK_PERIOD_NS = 20;
    localparam int EBRA_OUT_CLK_DIV = 2;
    localparam int EBRA_MUX_TRI_GAP = 2;

    typedef enum logic [1:0] {ARB_OWN, ARB_GRANTED, ARB_REGAIN} ebra_arb_st_t;
    typedef enum logic [2:0] {
        CYC_IDLE, CYC_ADDR, CYC_DLY, CYC_CMD, CYC_WAIT, CYC_RDY, CYC_MUX,
        CYC_TRI
    } ebra_cyc_st_t;
endpackage : ebra_pkg

/* ebra_arb_if.sv */
// Interface between the cycle engine and the hold arbiter
`timescale 1ns/1ps
interface ebra_arb_if;
    logic tick;
    logic hold_n;
    logic cyc_idle;
    logic pending;
    logic grant;
    logic drive_en;
    logic may_start;
    logic regain_req;
    modport eng (output tick, hold_n, cyc_idle, pending,
                 input grant, drive_en, may_start, regain_req);
    modport arb (input tick, hold_n, cyc_idle, pending,
                 output grant, drive_en, may_start, regain_req);
endinterface : ebra_arb_if

/* ebra_arbiter.sv */
// Hold, hold-acknowledge and bus-request arbiter
`timescale 1ns/1ps
module ebra_arbiter (
    input wire logic pclk,     // System clock
    input wire logic presetn,  // Asynchronous reset, active low
    ebra_arb_if.arb arb        // Engine side
);
    import ebra_pkg::*;

    typedef struct packed {
        ebra_arb_st_t st;
        logic drive;
    } ebra_arb_state_t;

    ebra_arb_state_t s_q;
    ebra_arb_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (arb.tick)
        begin
            unique case (s_q.st)
                ARB_OWN:
                    // Only an idle engine is released
                    if (!arb.hold_n && arb.cyc_idle)
                    begin
                        s_d.st = ARB_GRANTED;
                        s_d.drive = 1'b0;
                    end
                ARB_GRANTED:
                    // Regain follows hold going high only
                    if (arb.hold_n)
                        s_d.st = ARB_REGAIN;
                ARB_REGAIN:
                begin
                    s_d.st = ARB_OWN;
                    s_d.drive = 1'b1;  // Drive again one clock after grant drops
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '{st: ARB_OWN, drive: 1'b1};
        else
            s_q <= s_d;
    end

    assign arb.grant = (s_q.st == ARB_GRANTED);
    assign arb.drive_en = s_q.drive;
    assign arb.may_start = (s_q.st == ARB_OWN) && arb.hold_n && arb.tick;
    assign arb.regain_req = (s_q.st == ARB_GRANTED) && arb.pending;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_grant_after_idle: assert property ($rose(arb.grant) |->
        $past(arb.cyc_idle) && !$past(arb.hold_n))
        else $error("Bus granted while a cycle was running");
    a_regain_on_hold: assert property ($fell(arb.grant) |->
        $past(arb.hold_n) && $past(arb.tick))
        else $error("Grant dropped without hold going high");
    a_drive_after_drop: assert property ($fell(arb.grant) |->
        !arb.drive_en ##1 !arb.drive_en [*1] ##1 arb.drive_en)
        else $error("Outputs not driven again one clock after grant drop");
endmodule : ebra_arbiter

/* ebra_ext_model.sv */
// Far-side model: external memory answering with ready, fast or slow
`timescale 1ns/1ps
module ebra_ext_model (
    input wire logic pclk,           // System clock
    input wire logic presetn,        // Reset, active low
    input wire logic rd_n,           // Read strobe line
    input wire logic wr_n,           // Write strobe line
    input wire logic [15:0] addr,    // Address line
    input wire logic [15:0] wdata,   // Data driven by the device
    input wire logic [1:0] slow,     // Extra ready wait states wanted
    output logic ready_n,            // Ready, active low
    output logic [15:0] rdata,       // Data towards the device
    output logic [15:0] last_wr      // Last word written
);
    logic [3:0] cnt_q;
    logic [15:0] word;
    assign word = addr ^ 16'hA5C3;
    // Outside the read strobe the bus shows the inverse, so a late capture
    // is seen as wrong data
    assign rdata = !rd_n ? word : ~word;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 4'h0;
            ready_n <= 1'b1;
            last_wr <= 16'h0;
        end
        else if (rd_n && wr_n)
        begin
            // Ready withdrawn once the strobe has risen
            cnt_q <= 4'h0;
            ready_n <= 1'b1;
        end
        else
        begin
            if (cnt_q != 4'hF)
                cnt_q <= cnt_q + 4'h1;
            ready_n <= (cnt_q + 4'h1) < ({1'b0, slow, 1'b0} + 4'h2);
            if (!wr_n)
                last_wr <= wdata;
        end
    end
endmodule : ebra_ext_model

/* ebra_top_tb.sv */
// Testbench for the external bus ready and hold block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    mismatches++; $display("ERROR %0t got %0h exp %0h", $time, a, b); \
    end end
module ebra_top_tb;
    import ebra_pkg::*;
    localparam logic [6:0] CTL [5] = '{7'h00, 7'h10, 7'h63, 7'h20, 7'h50};
    localparam int SL [5] = '{0, 0, 0, 2, 1};
    localparam bit WR [5] = '{0, 1, 0, 0, 1};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic system_clock_output, ext_addr_oe, ext_data_oe, ext_rd_n_o;
    logic ext_wr_n_o, ext_strobe_oe, ext_cs_n_o, ext_cs_n_oe, ext_ready_n;
    logic ext_hold_n, bus_hold_grant_out, bus_regain_request_out;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] ext_addr_o, ext_data_o, din, mrd, last_wr, a;
    logic [1:0] slow;
    logic cs_line, rd_line, wr_line;
    int cs_cnt, st_cnt, n;
    int mismatches = 0;
    int total_checks = 0;
    assign cs_line = ext_cs_n_oe ? ext_cs_n_o : 1'b1;
    assign rd_line = ext_strobe_oe ? ext_rd_n_o : 1'b1;
    assign wr_line = ext_strobe_oe ? ext_wr_n_o : 1'b1;
    assign din = ext_data_oe ? ext_data_o : mrd;
    ebra_top i_ebra_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .system_clock_output,
        .ext_addr_o, .ext_addr_oe, .ext_data_i(din), .ext_data_o,
        .ext_data_oe, .ext_rd_n_o, .ext_wr_n_o, .ext_strobe_oe, .ext_cs_n_o,
        .ext_cs_n_oe, .ext_ready_n, .ext_hold_n, .bus_hold_grant_out,
        .bus_regain_request_out);
    ebra_ext_model i_ebra_ext_model (.pclk, .presetn, .rd_n(rd_line),
        .wr_n(wr_line), .addr(ext_addr_o), .wdata(ext_data_o), .slow,
        .ready_n(ext_ready_n), .rdata(mrd), .last_wr);
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (cs_line === 1'b0) cs_cnt++;
        if (rd_line === 1'b0 || wr_line === 1'b0) st_cnt++;
    end
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] d, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a stalled access
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_idle;
        logic [31:0] s;
        for (int k = 0; k < 100; k++)
        begin
            apb(1'b0, EBRA_OFF_STATUS, 32'h0, s);
            if (s[0] === 1'b0) break;
        end
        `CHK(s[0], 1'b0)
    endtask : wait_idle
    task automatic wait_grant(input logic v);
        for (int k = 0; k < 100; k++)
        begin
            @(posedge pclk);
            if (bus_hold_grant_out === v) break;
        end
        `CHK(bus_hold_grant_out, v)
    endtask : wait_grant
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        test_done();
    end
    initial
    begin
        {psel, penable, pwrite, presetn, slow} = '0;
        {paddr, pwdata} = '0;
        ext_hold_n = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(bus_hold_grant_out, 1'b0)
        @(posedge pclk);
        a[0] = system_clock_output;
        @(posedge pclk);
        `CHK(system_clock_output, ~a[0])
        apb(1'b0, EBRA_OFF_STATUS, 32'h0, r);
        `CHK(r, 32'h0)
        apb(1'b0, 8'h18, 32'h0, r);
        `CHK({err, r}, 33'h1_0000_0000)
        for (int i = 0; i < 5; i++)
        begin
            a = 16'h1230 + 16'(i);
            apb(1'b1, EBRA_OFF_CTRL, {25'h0, CTL[i]}, r);
            apb(1'b1, EBRA_OFF_ADDR, {16'h0, a}, r);
            apb(1'b1, EBRA_OFF_WDATA, {16'h0, ~a}, r);
            slow <= 2'(SL[i]);
            cs_cnt = 0;
            st_cnt = 0;
            apb(1'b1, EBRA_OFF_CMD, {30'h0, WR[i], 1'b1}, r);
            wait_idle();
            n = int'(CTL[i][3:0]) + SL[i];
            `CHK(cs_cnt, 2 * (3 + n + int'(CTL[i][4])))
            `CHK(st_cnt, 2 * (2 + n))
            apb(1'b0, EBRA_OFF_RDATA, 32'h0, r);
            if (WR[i]) `CHK(last_wr, ~a)
            else `CHK(r[15:0], a ^ 16'hA5C3)
        end
        slow <= 2'd2;
        apb(1'b1, EBRA_OFF_CTRL, 32'h0, r);
        apb(1'b1, EBRA_OFF_ADDR, 32'h4000, r);
        st_cnt = 0;
        apb(1'b1, EBRA_OFF_CMD, 32'h1, r);
        // Hold arrives while the read strobe is already running
        do
            @(posedge pclk);
        while (rd_line !== 1'b0);
        ext_hold_n <= 1'b0;
        wait_grant(1'b1);
        `CHK(st_cnt, 8)
        `CHK({cs_line, ext_cs_n_oe}, 2'b10)
        `CHK(ext_addr_oe, 1'b0)
        cs_cnt = 0;
        apb(1'b1, EBRA_OFF_CMD, 32'h1, r);
        repeat (10) @(posedge pclk);
        `CHK(bus_regain_request_out, 1'b1)
        `CHK(bus_hold_grant_out, 1'b1)
        `CHK(cs_cnt, 0)
        ext_hold_n <= 1'b1;
        wait_grant(1'b0);
        `CHK(ext_addr_oe, 1'b0)
        wait_idle();
        apb(1'b0, EBRA_OFF_RDATA, 32'h0, r);
        `CHK(r[15:0], 16'h4000 ^ 16'hA5C3)
        `CHK(bus_regain_request_out, 1'b0)
        ext_hold_n <= 1'b0;
        wait_grant(1'b1);
        ext_hold_n <= 1'b1;
        wait_grant(1'b0);
        test_done();
    end
endmodule : ebra_top_tb
